// *** inc/autoflow_defines.vh ***
// Register offsets, field positions and reset values of the autoflow block.
// Included by the autoflow logic; definitions only.
`ifndef AUTOFLOW_DEFINES_VH
`define AUTOFLOW_DEFINES_VH

// Register byte offsets
`define OFS_MODEM_CONTROL 8'h00
`define OFS_ENHANCED_FEATURE 8'h04
`define OFS_MODEM_STATUS 8'h08
`define OFS_FLOW_CONFIG 8'h0C
`define OFS_FLOW_STATUS 8'h10

// Modem control fields
`define MCR_RTS_BIT 1
`define MCR_LOOPBACK_BIT 4
`define MCR_AUTOFLOW_BIT 5
// Enhanced feature fields
`define EFR_AUTO_RTS_BIT 6
`define EFR_AUTO_CTS_BIT 7
// Modem status fields
`define MSR_DELTA_CTS_BIT 0
`define MSR_RING_EDGE_BIT 2
`define MSR_CTS_BIT 4
`define MSR_RING_BIT 6
// Flow config fields
`define CFG_RX_TRIG_LSB 0
`define CFG_RX_TRIG_MSB 1
`define CFG_TX_TRIG_LSB 4
`define CFG_TX_TRIG_MSB 7
`define CFG_MSR_IRQ_EN_BIT 8

// Receive trigger level codes and levels
`define RX_TRIG_CODE_1 2'h0
`define RX_TRIG_CODE_4 2'h1
`define RX_TRIG_CODE_8 2'h2
`define RX_TRIG_CODE_14 2'h3
`define RX_TRIG_LEVEL_1 5'h01
`define RX_TRIG_LEVEL_4 5'h04
`define RX_TRIG_LEVEL_8 5'h08
`define RX_TRIG_LEVEL_14 5'h0E

// Reset values
`define MCR_RESET 8'h00
`define EFR_RESET 8'h00
`define CFG_RESET 9'h001
`define SYNC_RESET 3'h7

`endif

// *** logic/pin_sync.v ***
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the pins idle at the reset level given by the parameter.
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] RESET_LEVEL = {WIDTH{1'b1}}
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] pin_sync_out
);
	reg [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= RESET_LEVEL;
			pin_sync_out <= RESET_LEVEL;
		end
		else
		begin
			meta <= pin_in;
			pin_sync_out <= meta;
		end
	end
endmodule // pin_sync

// *** logic/uart_autoflow_control.v ***
// Autoflow control, handshake pins and loopback routing of one serial channel.
// Assumes the receiver, transmitter and FIFOs sit outside on pclk and report
// their levels here; pins arrive asynchronously and are synchronised inside.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "autoflow_defines.vh"
module uart_autoflow_control #(
	parameter FIFO_DEPTH = 16,
	parameter LEVEL_W = 5
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ring_indicate_n_chan_a,
	input wire clear_send_n_chan_a,
	input wire serial_in_chan_a,
	output reg serial_out_chan_a,
	output reg request_send_n_chan_a,
	output reg receive_ready_n_chan_a,
	output reg transmit_ready_n_chan_a,
	input wire [LEVEL_W-1:0] rx_level,
	input wire rx_timeout,
	input wire rx_error,
	input wire rx_first_data_bit,
	input wire [LEVEL_W-1:0] tx_space,
	input wire tx_serial_core,
	output reg rx_serial_core,
	output wire rx_accept,
	output wire tx_start_ok,
	output wire modem_status_irq
);
	localparam [LEVEL_W-1:0] DEPTH = FIFO_DEPTH[LEVEL_W-1:0];
	localparam [LEVEL_W-1:0] ZERO_LEVEL = {LEVEL_W{1'b0}};

	reg [7:0] modem_control_reg;
	reg [7:0] enhanced_feature_reg;
	reg [8:0] flow_config;
	reg delta_cts;
	reg ring_edge;
	reg ring_prev;
	reg cts_prev;
	reg rts_hold;
	wire [2:0] pins_sync;
	wire ring_s;
	wire cts_n_s;
	wire serial_in_s;
	wire auto_rts_en;
	wire auto_cts_en;
	wire loopback;
	wire [1:0] rx_trig_code;
	wire [LEVEL_W-1:0] rx_trig_level;
	wire [3:0] tx_trig;
	wire wr_access;
	wire rd_done;
	wire setup;
	wire ring_rise;
	wire cts_change;
	wire rd_status;
	reg next_rts_hold;
	reg [31:0] next_prdata;
	reg next_err;
	reg [8:0] status_word;

	// Trigger code to byte count, used by receive-ready and flow control
	function [LEVEL_W-1:0] trig_level;
		input [1:0] code;
		begin
			case (code)
				`RX_TRIG_CODE_1: trig_level = `RX_TRIG_LEVEL_1;
				`RX_TRIG_CODE_4: trig_level = `RX_TRIG_LEVEL_4;
				`RX_TRIG_CODE_8: trig_level = `RX_TRIG_LEVEL_8;
				default: trig_level = `RX_TRIG_LEVEL_14;
			endcase
		end
	endfunction

	// Pins cross into pclk before anything looks at them
	pin_sync #(
		.WIDTH(3),
		.RESET_LEVEL(`SYNC_RESET)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in({serial_in_chan_a, clear_send_n_chan_a, ring_indicate_n_chan_a}),
		.pin_sync_out(pins_sync)
	);
	assign ring_s = pins_sync[0];
	assign cts_n_s = pins_sync[1];
	assign serial_in_s = pins_sync[2];

	// Mode decode; both enables need the feature bit and the autoflow bit
	// automatic RTS gating
	assign auto_rts_en = enhanced_feature_reg[`EFR_AUTO_RTS_BIT]
		& modem_control_reg[`MCR_AUTOFLOW_BIT] & modem_control_reg[`MCR_RTS_BIT];
	assign auto_cts_en = enhanced_feature_reg[`EFR_AUTO_CTS_BIT]
		& modem_control_reg[`MCR_AUTOFLOW_BIT];
	assign loopback = modem_control_reg[`MCR_LOOPBACK_BIT];
	assign rx_trig_code = flow_config[`CFG_RX_TRIG_MSB:`CFG_RX_TRIG_LSB];
	assign rx_trig_level = trig_level(rx_trig_code);
	assign tx_trig = flow_config[`CFG_TX_TRIG_MSB:`CFG_TX_TRIG_LSB];

	// APB phase decode
	assign setup = psel & ~penable;
	assign wr_access = psel & penable & pready & pwrite;
	assign rd_done = psel & penable & pready & ~pwrite;
	assign rd_status = rd_done & (paddr == `OFS_MODEM_STATUS);

	// next byte starts only while CTS is low
	// without automatic CTS the transmitter is never held
	assign tx_start_ok = ~auto_cts_en | ~cts_n_s;

	// no refusal after RTS drops; only a full FIFO stops the receiver
	assign rx_accept = (rx_level < DEPTH);

	// Ring indicator rises when the active-low pin returns high
	assign ring_rise = ring_s & ~ring_prev;
	assign cts_change = cts_n_s ^ cts_prev;

	// interrupt from sticky flags, gated by the enable bit
	assign modem_status_irq = flow_config[`CFG_MSR_IRQ_EN_BIT] & (ring_edge | delta_cts);

	// Edge history of synchronised pins
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ring_prev <= 1'b1;
			cts_prev <= 1'b1;
		end
		else
		begin
			ring_prev <= ring_s;
			cts_prev <= cts_n_s;
		end
	end

	// Sticky status flags; a new event wins over the clear by read
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ring_edge <= 1'b0;
			delta_cts <= 1'b0;
		end
		else
		begin
			if (ring_rise)
				ring_edge <= 1'b1;
			else if (rd_status)
				ring_edge <= 1'b0;
			// CTS moves are silent while flow control owns it
			if (cts_change & ~auto_cts_en)
				delta_cts <= 1'b1;
			else if (rd_status)
				delta_cts <= 1'b0;
		end
	end

	// Software registers, written at the completing APB edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			modem_control_reg <= `MCR_RESET;
			enhanced_feature_reg <= `EFR_RESET;
			flow_config <= `CFG_RESET;
		end
		else if (wr_access)
		begin
			if (paddr == `OFS_MODEM_CONTROL)
				modem_control_reg <= pwdata[7:0];
			else if (paddr == `OFS_ENHANCED_FEATURE)
				enhanced_feature_reg <= pwdata[7:0];
			else if (paddr == `OFS_FLOW_CONFIG)
				flow_config <= pwdata[8:0];
		end
	end

	// Receive flow hold; trigger 14 waits for the sixteenth character itself
	always @*
	begin
		next_rts_hold = rts_hold;
		if (rx_trig_code == `RX_TRIG_CODE_14)
		begin
			// hold at first data bit of the sixteenth character
			if (rx_first_data_bit && rx_level >= DEPTH - 5'h01)
				next_rts_hold = 1'b1;
			// release once two bytes of space have been read free
			else if (rx_level < DEPTH - 5'h01)
				next_rts_hold = 1'b0;
		end
		else
		begin
			if (rx_level >= rx_trig_level)
				next_rts_hold = 1'b1;
			// release only once the FIFO is drained
			else if (rx_level == ZERO_LEVEL)
				next_rts_hold = 1'b0;
		end
	end

	// Handshake pin registers; all pins idle high out of reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rts_hold <= 1'b0;
			request_send_n_chan_a <= 1'b1;
			receive_ready_n_chan_a <= 1'b1;
			transmit_ready_n_chan_a <= 1'b1;
		end
		else
		begin
			rts_hold <= next_rts_hold;
			// asserted is low, deasserted is high
			request_send_n_chan_a <= ~(modem_control_reg[`MCR_RTS_BIT]
				& ~(auto_rts_en & next_rts_hold));
			// empty or error releases receive-ready first
			if (rx_level == ZERO_LEVEL || rx_error)
				receive_ready_n_chan_a <= 1'b1;
			else if (rx_level >= rx_trig_level || rx_timeout)
				receive_ready_n_chan_a <= 1'b0;
			if (tx_space == ZERO_LEVEL)
				transmit_ready_n_chan_a <= 1'b1;
			else if (tx_space >= {1'b0, tx_trig})
				transmit_ready_n_chan_a <= 1'b0;
		end
	end

	// Serial routing; the loopback mux is registered to keep outputs glitch free
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_out_chan_a <= 1'b1;
			rx_serial_core <= 1'b1;
		end
		else
		begin
			// loopback: pin held at mark, receiver fed from transmitter
			serial_out_chan_a <= loopback ? 1'b1 : tx_serial_core;
			rx_serial_core <= loopback ? tx_serial_core : serial_in_s;
		end
	end

	// Read mux for the flow status word
	always @*
	begin
		status_word = 9'h000;
		status_word[LEVEL_W-1:0] = rx_level;
		status_word[5] = rts_hold;
		status_word[6] = auto_rts_en;
		status_word[7] = auto_cts_en;
		status_word[8] = tx_start_ok;
	end

	// Address decode for reads and the error answer
	always @*
	begin
		next_prdata = 32'h00000000;
		next_err = 1'b0;
		if (paddr == `OFS_MODEM_CONTROL)
			next_prdata[7:0] = modem_control_reg;
		else if (paddr == `OFS_ENHANCED_FEATURE)
			next_prdata[7:0] = enhanced_feature_reg;
		else if (paddr == `OFS_MODEM_STATUS)
		begin
			next_prdata[`MSR_DELTA_CTS_BIT] = delta_cts | (cts_change & ~auto_cts_en); // Setup-edge event
			next_prdata[`MSR_RING_EDGE_BIT] = ring_edge | ring_rise; // Not lost to the clear
			next_prdata[`MSR_CTS_BIT] = ~cts_n_s;
			// ring level shown as active high
			next_prdata[`MSR_RING_BIT] = ~ring_s;
		end
		else if (paddr == `OFS_FLOW_CONFIG)
			next_prdata[8:0] = flow_config;
		else if (paddr == `OFS_FLOW_STATUS)
			next_prdata[8:0] = status_word;
		else
			next_err = 1'b1;
	end

	// One-cycle access phase; data captured at setup so prdata is a flop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= setup;
			if (setup)
			begin
				pslverr <= next_err;
				prdata <= pwrite ? 32'h00000000 : next_prdata;
			end
			else if (!psel)
				pslverr <= 1'b0;
		end
	end
endmodule // uart_autoflow_control

// *** tb/autoflow_checker_assertions.sv ***
// Checker of the autoflow block: pin, level and routing relations.
// Assumes zero-wait register writes and level inputs on pclk.
`timescale 1ns/1ps
module autoflow_checker #(
	parameter FIFO_DEPTH = 16,
	parameter LEVEL_W = 5
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire clear_send_n_chan_a,
	input wire serial_in_chan_a,
	input wire serial_out_chan_a,
	input wire request_send_n_chan_a,
	input wire receive_ready_n_chan_a,
	input wire transmit_ready_n_chan_a,
	input wire [LEVEL_W-1:0] rx_level,
	input wire rx_timeout,
	input wire rx_error,
	input wire [LEVEL_W-1:0] tx_space,
	input wire tx_serial_core,
	input wire rx_serial_core,
	input wire rx_accept,
	input wire tx_start_ok
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	rts_reset_a: assert property ($rose(presetn) |-> request_send_n_chan_a)
		else $error("rts low after reset");
	rts_write_a: assert property (psel && penable && pready && pwrite && paddr == 8'h00
		&& !pwdata[5] |-> ##2 request_send_n_chan_a == !$past(pwdata[1], 2))
		else $error("rts not following control write");
	rxrdy_empty_a: assert property ((rx_level == 0 || rx_error) |=> receive_ready_n_chan_a)
		else $error("receive ready low while empty");
	rxrdy_timeout_a: assert property (rx_timeout && rx_level != 0 && !rx_error
		|=> !receive_ready_n_chan_a)
		else $error("receive ready high after timeout");
	txrdy_full_a: assert property (tx_space == 0 |=> transmit_ready_n_chan_a)
		else $error("transmit ready low while full");
	cts_start_a: assert property (!clear_send_n_chan_a [*4] |-> tx_start_ok)
		else $error("start refused with cts active");
	tx_route_a: assert property (!serial_out_chan_a |-> !$past(tx_serial_core))
		else $error("serial out not from transmitter");
	rx_route_a: assert property (rx_serial_core == $past(tx_serial_core)
		|| rx_serial_core == $past(serial_in_chan_a, 3))
		else $error("receiver input from wrong source");
	accept_a: assert property (rx_accept == (rx_level < FIFO_DEPTH))
		else $error("accept does not match fill level");
endmodule // autoflow_checker

bind uart_autoflow_control autoflow_checker #(.FIFO_DEPTH(FIFO_DEPTH), .LEVEL_W(LEVEL_W))
	u_autoflow_checker (.*);

// *** tb/remote_peer.sv ***
// Remote serial peer: drives our clear-to-send and receive line.
// Assumes the bench says when the peer wants our bytes halted.
`timescale 1ns/1ps
module remote_peer (
	input wire pclk,
	input wire presetn,
	input wire rts_n,
	input wire stop,
	output reg cts_n,
	output reg rx_line
);
	// halt via clear-to-send
	// Line idles high while our RTS is released, random data otherwise
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cts_n <= 1'b1;
			rx_line <= 1'b1;
		end
		else
		begin
			cts_n <= stop;
			rx_line <= rts_n ? 1'b1 : 1'($urandom);
		end
	end
endmodule // remote_peer

// *** tb/test_uart_autoflow_control.sv ***
// Bench of the autoflow block: APB master, FIFO level stimulus, remote peer.
// Assumes zero-wait APB answers and pins synchronised within a few clocks.
`timescale 1ns/1ps
`include "autoflow_defines.vh"
`define CHK(a, e) chk((a) === (e))
module test_uart_autoflow_control;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, t, stop = 1'b1, ring_indicate_n_chan_a = 1'b1;
	logic clear_send_n_chan_a, serial_in_chan_a, serial_out_chan_a, request_send_n_chan_a;
	logic receive_ready_n_chan_a, transmit_ready_n_chan_a, rx_serial_core;
	logic rx_accept, tx_start_ok, modem_status_irq, tx_serial_core = 1'b1;
	logic [4:0] rx_level = 5'h00, tx_space = 5'h10, lv, sp;
	logic rx_timeout = 1'b0, rx_error = 1'b0, rx_first_data_bit = 1'b0;
	logic rx_err_pick, exp_rx = 1'b0, exp_tx = 1'b0;
	int n_mismatch = 0, check_count = 0, cycles = 0;
	uart_autoflow_control u_uart_autoflow_control (.*);
	remote_peer u_remote_peer (.pclk(pclk), .presetn(presetn), .rts_n(request_send_n_chan_a),
		.stop(stop), .cts_n(clear_send_n_chan_a), .rx_line(serial_in_chan_a));
	always #4 pclk = ~pclk;
	// Random transmitter bits keep both serial routes busy
	always @(posedge pclk)
	begin
		tx_serial_core <= presetn ? 1'($urandom) : 1'b1;
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			final_report;
		end
	end
	task chk(input logic ok);
		check_count++;
		if (!ok)
		begin
			n_mismatch++;
			$display("MISMATCH at %0t: value differs", $time);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer, held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so a following call never reassigns psel in this step
		@(posedge pclk);
	endtask
	function logic [4:0] trig(input int c);
		return c == 0 ? 5'h01 : c == 1 ? 5'h04 : c == 2 ? 5'h08 : 5'h0E;
	endfunction
	// Receive-ready model: empty or error wins, trigger asserts, otherwise hold
	function logic rx_ready_exp(input logic [4:0] lvl, input logic e, input logic prev);
		if (lvl == 5'h00 || e)
			return 1'b1;
		if (lvl >= trig(1))
			return 1'b0;
		return prev;
	endfunction
	// Transmit-ready model with four trigger spaces: full wins, otherwise hold
	function logic tx_ready_exp(input logic [4:0] spaces, input logic prev);
		if (spaces == 5'h00)
			return 1'b1;
		if (spaces >= 5'h04)
			return 1'b0;
		return prev;
	endfunction
	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'hA244));
		step(16);
		presetn <= 1'b1;
		step(3);
		`CHK(request_send_n_chan_a, 1'b1);
		apb(1'b0, 8'h20, 32'h0);
		`CHK(err, 1'b1);
		apb(1'b1, `OFS_MODEM_CONTROL, 32'h2);
		step(3);
		`CHK(request_send_n_chan_a, 1'b0);
		apb(1'b1, `OFS_ENHANCED_FEATURE, 32'hC0);
		apb(1'b1, `OFS_MODEM_CONTROL, 32'h22);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, `OFS_FLOW_CONFIG, c);
			lv = trig(c);
			rx_level <= lv - 5'h01;
			step(3);
			`CHK(request_send_n_chan_a, 1'b0);
			rx_level <= lv + 5'h01;
			rx_first_data_bit <= 1'b1;
			@(posedge pclk);
			rx_first_data_bit <= 1'b0;
			step(3);
			`CHK(request_send_n_chan_a, 1'b1);
			`CHK(rx_accept, 1'b1);
			rx_level <= c == 3 ? 5'h0E : 5'h00;
			step(3);
			`CHK(request_send_n_chan_a, 1'b0);
		end
		apb(1'b1, `OFS_ENHANCED_FEATURE, 32'h80);
		rx_level <= 5'h10;
		step(3);
		`CHK(request_send_n_chan_a, 1'b0);
		`CHK(rx_accept, 1'b0);
		`CHK(tx_start_ok, 1'b0);
		stop <= 1'b0;
		step(5);
		`CHK(tx_start_ok, 1'b1);
		apb(1'b0, `OFS_MODEM_STATUS, 32'h0);
		`CHK(rd[0], 1'b0);
		stop <= 1'b1;
		step(5);
		`CHK(tx_start_ok, 1'b0);
		apb(1'b1, `OFS_ENHANCED_FEATURE, 32'h0);
		`CHK(tx_start_ok, 1'b1);
		stop <= 1'b0;
		step(5);
		`CHK(tx_start_ok, 1'b1);
		apb(1'b0, `OFS_MODEM_STATUS, 32'h0);
		`CHK(rd[0], 1'b1);
		apb(1'b1, `OFS_FLOW_CONFIG, 32'h141);
		ring_indicate_n_chan_a <= 1'b0;
		step(6);
		`CHK(modem_status_irq, 1'b0);
		apb(1'b0, `OFS_MODEM_STATUS, 32'h0);
		`CHK(rd[6], 1'b1);
		ring_indicate_n_chan_a <= 1'b1;
		step(6);
		`CHK(modem_status_irq, 1'b1);
		rx_level <= 5'h00;
		step(3);
		`CHK(receive_ready_n_chan_a, 1'b1);
		rx_level <= 5'h04;
		step(3);
		`CHK(receive_ready_n_chan_a, 1'b0);
		rx_error <= 1'b1;
		step(3);
		`CHK(receive_ready_n_chan_a, 1'b1);
		rx_error <= 1'b0;
		rx_level <= 5'h02;
		rx_timeout <= 1'b1;
		@(posedge pclk);
		rx_timeout <= 1'b0;
		step(2);
		`CHK(receive_ready_n_chan_a, 1'b0);
		tx_space <= 5'h00;
		step(3);
		`CHK(transmit_ready_n_chan_a, 1'b1);
		tx_space <= 5'h03;
		step(3);
		`CHK(transmit_ready_n_chan_a, 1'b1);
		tx_space <= 5'h04;
		step(3);
		`CHK(transmit_ready_n_chan_a, 1'b0);
		// random fill levels against the bench models
		for (int i = 0; i < 40; i++)
		begin
			lv = 5'($urandom_range(16));
			sp = 5'($urandom_range(16));
			rx_err_pick = ($urandom_range(7) == 0);
			rx_level <= lv;
			tx_space <= sp;
			rx_error <= rx_err_pick;
			step(2);
			exp_rx = rx_ready_exp(lv, rx_err_pick, exp_rx);
			exp_tx = tx_ready_exp(sp, exp_tx);
			`CHK(receive_ready_n_chan_a, exp_rx);
			`CHK(transmit_ready_n_chan_a, exp_tx);
		end
		for (int lb = 0; lb < 2; lb++)
		begin
			apb(1'b1, `OFS_MODEM_CONTROL, lb ? 32'h12 : 32'h02);
			step(2);
			repeat (8)
			begin
				@(posedge pclk);
				t = tx_serial_core;
				#1;
				`CHK(serial_out_chan_a, lb ? 1'b1 : t);
				if (lb)
					`CHK(rx_serial_core, t);
			end
		end
		final_report;
	end
endmodule // test_uart_autoflow_control
